// ---- hdl/nio_pkg.sv ----
// Constants shared by the nibble I/O register slice
// How it works
// - Port data nibble reads pin levels; writes set the output latch.
// - Initial reset clears the port output latch; pin readback stays live.
// - One direction bit, 1 output, 0 input, cleared at reset.
// - Three read-only watchdog stage bits, quarter, half, one hertz, reset zero.
// - Eight-bit serial data as low nibble then high nibble, read/write.
// - Two-bit serial clock mode: full, half, quarter, slave; resets to three.
// - Read/write serial shift edge select bit, cleared at reset.
// - Read/write serial interrupt enable bit, masked at reset.
// - Read-only serial interrupt factor flag, set by a serial event.
// - Read-only input group two interrupt factor flag, set by its cause.
// - Input group two pin levels readable as a read-only nibble.
// - Reading a register clears the interrupt factor flags it holds.
// - Strobe bits and unused bits always read as zero.
// - Four per-pin input group two interrupt enables, cleared at reset.
package nio_pkg;

  // ****************************************************
  // Bus geometry
  // ****************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NIB_W  = 4;
  localparam int IDX_W  = 10;

  // ****************************************************
  // Register indices; byte address is four times the index
  // ****************************************************
  localparam logic [IDX_W-1:0] IDX_PORT_DATA = 10'h2ed;
  localparam logic [IDX_W-1:0] IDX_TMR_DIR   = 10'h2ee;
  localparam logic [IDX_W-1:0] IDX_WDOG      = 10'h2ef;
  localparam logic [IDX_W-1:0] IDX_SD_LOW    = 10'h2f0;
  localparam logic [IDX_W-1:0] IDX_SD_HIGH   = 10'h2f1;
  localparam logic [IDX_W-1:0] IDX_SCLK_CFG  = 10'h2f2;
  localparam logic [IDX_W-1:0] IDX_FLAGS     = 10'h2f3;
  localparam logic [IDX_W-1:0] IDX_K2_LEVELS = 10'h2f4;
  localparam logic [IDX_W-1:0] IDX_K2_ENABLE = 10'h2f5;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int BIT_TMR_CLR  = 3;
  localparam int BIT_SW_RUN   = 2;
  localparam int BIT_SW_CLR   = 1;
  localparam int BIT_DIR      = 0;
  localparam int BIT_WD_CLR   = 3;
  localparam int BIT_SCS_HI   = 3;
  localparam int BIT_SCS_LO   = 2;
  localparam int BIT_EDGE     = 1;
  localparam int BIT_SIO_EN   = 0;
  localparam int BIT_K2_FLAG  = 1;
  localparam int BIT_SIO_FLAG = 0;
  localparam int STRB_LANE    = 0;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [NIB_W-1:0] RST_NIB  = 4'h0;
  localparam logic [7:0]       RST_BYTE = 8'h00;
  localparam logic [1:0]       RST_SCS  = 2'h3;
  localparam logic             RST_BIT  = 1'b0;

  // Serial clock source selection
  typedef enum logic [1:0] {
    NIO_SCLK_FULL    = 2'h0,
    NIO_SCLK_HALF    = 2'h1,
    NIO_SCLK_QUARTER = 2'h2,
    NIO_SCLK_SLAVE   = 2'h3
  } nio_sclk_mode_t;

endpackage : nio_pkg

// ---- hdl/nio_regs.sv ----
// Nibble I/O register slice: APB slave with port, timer, serial and input group registers
//
// Chosen here: the APB interface to the registers.
module nio_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bidirectional port pins
  input  wire logic [3:0]  bidir_port_pins_in,
  output logic      [3:0]  bidir_port_pins_out,
  output logic      [3:0]  bidir_port_pins_oe,
  // Timer controls
  output logic             clock_timer_clear_strobe,
  output logic             stopwatch_clear_strobe,
  output logic             watchdog_clear_strobe,
  output logic             stopwatch_run_bit,
  input  wire logic        watchdog_stage_quarter_hz,
  input  wire logic        watchdog_stage_half_hz,
  input  wire logic        watchdog_stage_one_hz,
  // Serial interface
  input  wire logic        serial_load,
  input  wire logic [7:0]  serial_load_data,
  input  wire logic        serial_done,
  output logic      [7:0]  serial_data,
  output logic      [1:0]  serial_clock_mode,
  output logic      [1:0]  serial_clk_halvings,
  output logic             serial_slave,
  output logic             serial_edge_select,
  output logic             serial_irq_enable,
  output logic             serial_irq_factor,
  // Input group two
  input  wire logic [3:0]  input_group_two_pins,
  output logic      [3:0]  input_group_two_irq_enable,
  output logic             input_group_two_irq_factor
);

  // ****************************************************
  // Decode helpers
  // ****************************************************

  // Word index of a byte address
  function automatic logic [9:0] reg_idx(input logic [11:0] a);
    return a[11:2];
  endfunction

  // True when an address selects the given register
  function automatic logic hits(input logic [11:0] a, input logic [9:0] idx);
    return reg_idx(a) == idx;
  endfunction

  // True when an address selects any register of the slice
  function automatic logic mapped(input logic [11:0] a);
    return reg_idx(a) >= nio_pkg::IDX_PORT_DATA && reg_idx(a) <= nio_pkg::IDX_K2_ENABLE;
  endfunction

  // ****************************************************
  // Signals
  // ****************************************************
  logic        setup;
  logic        done;
  logic        rd_done;
  logic        wr_done;
  logic [3:0]  port_latch_q;
  logic        port_dir_q;
  logic        sw_run_q;
  logic        tmr_clr_q;
  logic        sw_clr_q;
  logic        wd_clr_q;
  logic [7:0]  sdata_q;
  logic [1:0]  scs_q;
  logic        edge_q;
  logic        sio_en_q;
  logic        sio_flag_q;
  logic        k2_flag_q;
  logic [3:0]  k2_en_q;
  logic [3:0]  k2_prev_q;
  logic [3:0]  k2_cause;
  logic [3:0]  port_lvl;
  logic [3:0]  k2_lvl;
  logic [3:0]  rd_nib;
  logic [31:0] prdata_q;
  logic        err_q;
  logic        flags_rd_q;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  nio_sync #(.W(4)) u_port_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (bidir_port_pins_in),
    .sync_out (port_lvl)
  );

  nio_sync #(.W(4)) u_k2_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (input_group_two_pins),
    .sync_out (k2_lvl)
  );

  // ****************************************************
  // APB phases
  // ****************************************************

  // Zero wait states: every access phase completes at once
  assign setup   = psel && !penable;
  assign done    = psel && penable;
  assign rd_done = done && !pwrite;
  assign wr_done = done && pwrite && pstrb[nio_pkg::STRB_LANE];
  assign pready  = penable;
  assign pslverr = done && err_q;
  assign prdata  = prdata_q;

  // Read data is taken from flops in setup, so the access edge sees stable data
  always_comb begin
    rd_nib = nio_pkg::RST_NIB;
    unique case (reg_idx(paddr))
      nio_pkg::IDX_PORT_DATA: rd_nib = port_lvl;
      nio_pkg::IDX_TMR_DIR: begin
        rd_nib[nio_pkg::BIT_SW_RUN] = sw_run_q;
        rd_nib[nio_pkg::BIT_DIR]    = port_dir_q;  // Clear bits stay zero
      end
      nio_pkg::IDX_WDOG: rd_nib = {1'b0, watchdog_stage_quarter_hz,
                                   watchdog_stage_half_hz, watchdog_stage_one_hz};
      nio_pkg::IDX_SD_LOW:  rd_nib = sdata_q[3:0];
      nio_pkg::IDX_SD_HIGH: rd_nib = sdata_q[7:4];
      nio_pkg::IDX_SCLK_CFG: rd_nib = {scs_q, edge_q, sio_en_q};
      nio_pkg::IDX_FLAGS: begin
        rd_nib[nio_pkg::BIT_K2_FLAG]  = k2_flag_q;
        rd_nib[nio_pkg::BIT_SIO_FLAG] = sio_flag_q;
      end
      nio_pkg::IDX_K2_LEVELS: rd_nib = k2_lvl;
      nio_pkg::IDX_K2_ENABLE: rd_nib = k2_en_q;
      default: rd_nib = nio_pkg::RST_NIB;  // Unused upper bits and holes read zero
    endcase
  end

  // Capture read data and the error answer during setup
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_q   <= '0;
      err_q      <= 1'b0;
      flags_rd_q <= 1'b0;
    end else if (setup) begin
      prdata_q   <= {28'h0000000, rd_nib};
      err_q      <= !mapped(paddr);
      flags_rd_q <= hits(paddr, nio_pkg::IDX_FLAGS);
    end
  end

  // ****************************************************
  // Bidirectional port
  // ****************************************************

  // Output latch: cleared at reset, loaded by software
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_latch_q <= nio_pkg::RST_NIB;
    end else if (wr_done && hits(paddr, nio_pkg::IDX_PORT_DATA)) begin
      port_latch_q <= pwdata[3:0];
    end
  end

  // Direction and stopwatch run share a register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_dir_q <= nio_pkg::RST_BIT;
      sw_run_q   <= nio_pkg::RST_BIT;
    end else if (wr_done && hits(paddr, nio_pkg::IDX_TMR_DIR)) begin
      port_dir_q <= pwdata[nio_pkg::BIT_DIR];
      sw_run_q   <= pwdata[nio_pkg::BIT_SW_RUN];
    end
  end

  assign bidir_port_pins_out = port_latch_q;
  assign bidir_port_pins_oe  = {4{port_dir_q}};
  assign stopwatch_run_bit   = sw_run_q;

  // ****************************************************
  // Counter clear strobes
  // ****************************************************

  // One-cycle pulses after the completing edge; a written zero does nothing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tmr_clr_q <= 1'b0;
      sw_clr_q  <= 1'b0;
      wd_clr_q  <= 1'b0;
    end else begin
      tmr_clr_q <= wr_done && hits(paddr, nio_pkg::IDX_TMR_DIR) && pwdata[nio_pkg::BIT_TMR_CLR];
      sw_clr_q  <= wr_done && hits(paddr, nio_pkg::IDX_TMR_DIR) && pwdata[nio_pkg::BIT_SW_CLR];
      wd_clr_q  <= wr_done && hits(paddr, nio_pkg::IDX_WDOG) && pwdata[nio_pkg::BIT_WD_CLR];
    end
  end

  assign clock_timer_clear_strobe = tmr_clr_q;
  assign stopwatch_clear_strobe   = sw_clr_q;
  assign watchdog_clear_strobe    = wd_clr_q;

  // ****************************************************
  // Serial interface registers
  // ****************************************************

  // Software write beats a shifter load in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sdata_q <= nio_pkg::RST_BYTE;
    end else if (wr_done && hits(paddr, nio_pkg::IDX_SD_LOW)) begin
      sdata_q[3:0] <= pwdata[3:0];
    end else if (wr_done && hits(paddr, nio_pkg::IDX_SD_HIGH)) begin
      sdata_q[7:4] <= pwdata[3:0];
    end else if (serial_load) begin
      sdata_q <= serial_load_data;
    end
  end

  // Clock mode, edge and enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scs_q    <= nio_pkg::RST_SCS;
      edge_q   <= nio_pkg::RST_BIT;
      sio_en_q <= nio_pkg::RST_BIT;
    end else if (wr_done && hits(paddr, nio_pkg::IDX_SCLK_CFG)) begin
      scs_q    <= {pwdata[nio_pkg::BIT_SCS_HI], pwdata[nio_pkg::BIT_SCS_LO]};
      edge_q   <= pwdata[nio_pkg::BIT_EDGE];
      sio_en_q <= pwdata[nio_pkg::BIT_SIO_EN];
    end
  end

  // Mode decode for the shifter: number of clock halvings, or slave
  always_comb begin
    serial_clk_halvings = 2'h0;
    serial_slave        = 1'b0;
    unique case (nio_pkg::nio_sclk_mode_t'(scs_q))
      nio_pkg::NIO_SCLK_FULL:    serial_clk_halvings = 2'h0;
      nio_pkg::NIO_SCLK_HALF:    serial_clk_halvings = 2'h1;
      nio_pkg::NIO_SCLK_QUARTER: serial_clk_halvings = 2'h2;
      nio_pkg::NIO_SCLK_SLAVE:   serial_slave        = 1'b1;
    endcase
  end

  assign serial_data        = sdata_q;
  assign serial_clock_mode  = scs_q;
  assign serial_edge_select = edge_q;
  assign serial_irq_enable  = sio_en_q;

  // ****************************************************
  // Input group two
  // ****************************************************

  // Enables, one per pin
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      k2_en_q <= nio_pkg::RST_NIB;
    end else if (wr_done && hits(paddr, nio_pkg::IDX_K2_ENABLE)) begin
      k2_en_q <= pwdata[3:0];
    end
  end

  // Previous synchronised levels for change detection
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      k2_prev_q <= nio_pkg::RST_NIB;
    end else begin
      k2_prev_q <= k2_lvl;
    end
  end

  // A level change on an enabled pin is a cause
  for (genvar i = 0; i < nio_pkg::NIB_W; i++) begin : g_k2_cause
    assign k2_cause[i] = k2_en_q[i] && (k2_lvl[i] != k2_prev_q[i]);
  end

  assign input_group_two_irq_enable = k2_en_q;

  // ****************************************************
  // Interrupt factor flags
  // ****************************************************

  // Only bits seen as one in the read are cleared, so a flag set after the
  // setup capture survives the read; a set in the clear cycle also wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sio_flag_q <= 1'b0;
      k2_flag_q  <= 1'b0;
    end else begin
      if (serial_done) begin
        sio_flag_q <= 1'b1;
      end else if (rd_done && flags_rd_q && prdata_q[nio_pkg::BIT_SIO_FLAG]) begin
        sio_flag_q <= 1'b0;
      end
      if (|k2_cause) begin
        k2_flag_q <= 1'b1;
      end else if (rd_done && flags_rd_q && prdata_q[nio_pkg::BIT_K2_FLAG]) begin
        k2_flag_q <= 1'b0;
      end
    end
  end

  assign serial_irq_factor          = sio_flag_q;
  assign input_group_two_irq_factor = k2_flag_q;

  // ****************************************************
  // Checks
  // ****************************************************

  chk_latch_reset: assert property (
    @(posedge clk) $past(!reset_n) |-> bidir_port_pins_out == 4'h0)
    else $error("port latch not cleared by reset");

  chk_dir_drive: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(!reset_n) |-> bidir_port_pins_oe == 4'h0 ##0 !port_dir_q)
    else $error("port not input after reset");

  chk_mode_reset: assert property (
    @(posedge clk) $past(!reset_n) |-> serial_clock_mode == nio_pkg::RST_SCS && serial_slave)
    else $error("serial clock mode reset wrong");

  chk_mode_decode: assert property (
    @(posedge clk) disable iff (!reset_n)
    serial_slave == (serial_clock_mode == nio_pkg::NIO_SCLK_SLAVE) &&
    serial_clk_halvings == ((serial_clock_mode == nio_pkg::NIO_SCLK_SLAVE) ? 2'h0 : serial_clock_mode))
    else $error("serial clock mode decode wrong");

  chk_strobe_pulse: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_done && hits(paddr, nio_pkg::IDX_WDOG) && pwdata[nio_pkg::BIT_WD_CLR] |=>
    watchdog_clear_strobe ##1 !watchdog_clear_strobe)
    else $error("watchdog clear strobe not a single pulse");

  chk_strobe_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    !$past(wr_done) |-> !clock_timer_clear_strobe && !stopwatch_clear_strobe)
    else $error("clear strobe without a write");

  chk_strobe_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_done && hits(paddr, nio_pkg::IDX_TMR_DIR) |->
    prdata[nio_pkg::BIT_TMR_CLR] == 1'b0 && prdata[nio_pkg::BIT_SW_CLR] == 1'b0)
    else $error("clear strobe bits read nonzero");

  chk_sio_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    serial_done |=> serial_irq_factor [*2])
    else $error("serial event lost");

  chk_flag_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_done && hits(paddr, nio_pkg::IDX_FLAGS) && prdata[nio_pkg::BIT_SIO_FLAG] && !serial_done |=>
    !serial_irq_factor)
    else $error("serial flag not cleared by read");

  chk_k2_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    |(k2_en_q & (k2_lvl ^ k2_prev_q)) |=> input_group_two_irq_factor)
    else $error("input group cause lost");

  chk_k2_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_done && hits(paddr, nio_pkg::IDX_K2_LEVELS) |-> prdata[3:0] == $past(k2_lvl))
    else $error("input group levels misread");

endmodule // nio_regs

// ---- hdl/nio_sync.sv ----
// Two-stage synchroniser for pin levels entering the clock domain
module nio_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second; nothing else may look at it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // nio_sync

// ---- sim/nio_regs_tb_top.sv ----
// Self-checking bench for the nibble I/O register slice
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, (exp), (got)); end end

module nio_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************
  // Signals
  // ****************************************************
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, pin_in, pin_out, pin_oe, k2_pins, k2_en;
  logic        tmr_stb, sw_stb, wd_stb, sw_run, wd_q, wd_h, wd_o;
  logic        sload, sdone, sslave, sedge, sien, sifac, k2_fac;
  logic [7:0]  sload_d, sdata;
  logic [1:0]  smode, shalv;
  int          error_cnt, n_checks, cyc;

  // Byte addresses are four times the register index
  localparam logic [11:0] A_PORT = {nio_pkg::IDX_PORT_DATA, 2'b00};
  localparam logic [11:0] A_TMR  = {nio_pkg::IDX_TMR_DIR, 2'b00};
  localparam logic [11:0] A_WD   = {nio_pkg::IDX_WDOG, 2'b00};
  localparam logic [11:0] A_SDL  = {nio_pkg::IDX_SD_LOW, 2'b00};
  localparam logic [11:0] A_SDH  = {nio_pkg::IDX_SD_HIGH, 2'b00};
  localparam logic [11:0] A_CFG  = {nio_pkg::IDX_SCLK_CFG, 2'b00};
  localparam logic [11:0] A_FLG  = {nio_pkg::IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_K2L  = {nio_pkg::IDX_K2_LEVELS, 2'b00};
  localparam logic [11:0] A_K2E  = {nio_pkg::IDX_K2_ENABLE, 2'b00};

  nio_regs nio_regs_inst (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bidir_port_pins_in(pin_in), .bidir_port_pins_out(pin_out), .bidir_port_pins_oe(pin_oe),
    .clock_timer_clear_strobe(tmr_stb), .stopwatch_clear_strobe(sw_stb), .watchdog_clear_strobe(wd_stb),
    .stopwatch_run_bit(sw_run), .watchdog_stage_quarter_hz(wd_q), .watchdog_stage_half_hz(wd_h),
    .watchdog_stage_one_hz(wd_o), .serial_load(sload), .serial_load_data(sload_d), .serial_done(sdone),
    .serial_data(sdata), .serial_clock_mode(smode), .serial_clk_halvings(shalv), .serial_slave(sslave),
    .serial_edge_select(sedge), .serial_irq_enable(sien), .serial_irq_factor(sifac),
    .input_group_two_pins(k2_pins), .input_group_two_irq_enable(k2_en),
    .input_group_two_irq_factor(k2_fac)
  );

  // ****************************************************
  // Bus and check helpers
  // ****************************************************
  // One APB transfer; the wait has no own bound, the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [3:0] wd,
                     output logic [3:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {28'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata[3:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] d);
    logic [3:0] r;
    logic       e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [3:0] exp);
    logic [3:0] r;
    logic       e;
    apb(1'b0, a, 4'h0, r, e);
    `CHK(nm, exp, r);
  endtask

  // Strobes must pulse for exactly the cycle after the write lands
  task automatic stb_chk(input logic [11:0] a, input logic [3:0] d, input logic [2:0] exp);
    wr(a, d);
    #1;
    `CHK("strobes", exp, {tmr_stb, sw_stb, wd_stb});
    @(posedge clk);
    #1;
    `CHK("strobes end", 3'h0, {tmr_stb, sw_stb, wd_stb});
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset;
    `CHK("pins_out", 4'h0, pin_out);
    `CHK("pins_oe", 4'h0, pin_oe);
    `CHK("run", 1'b0, sw_run);
    `CHK("slave", 3'h7, {smode, sslave});
    `CHK("edge en", 2'h0, {sedge, sien});
    `CHK("factors", 2'h0, {k2_fac, sifac});
    `CHK("k2_en", 4'h0, k2_en);
    rd_chk("dir", A_TMR, 4'h0);
    rd_chk("wdog", A_WD, 4'h0);
    rd_chk("cfg", A_CFG, 4'hc);
  endtask

  task automatic t_port;
    pin_in <= 4'h5;
    wr(A_PORT, 4'ha);
    #1;
    `CHK("latch", 4'ha, pin_out);
    `CHK("oe in", 4'h0, pin_oe);
    wr(A_TMR, 4'h1);
    #1;
    `CHK("oe out", 4'hf, pin_oe);
    rd_chk("port rd", A_PORT, 4'h5);
    rd_chk("dir rd", A_TMR, 4'h1);
  endtask

  task automatic t_timers;
    stb_chk(A_TMR, 4'h8, 3'b100);
    stb_chk(A_TMR, 4'h2, 3'b010);
    stb_chk(A_WD, 4'h8, 3'b001);
    stb_chk(A_TMR, 4'h4, 3'b000);
    `CHK("run on", 1'b1, sw_run);
    rd_chk("tmr rd", A_TMR, 4'h4);
    wd_q <= 1'b1;
    wd_h <= 1'b0;
    wd_o <= 1'b1;
    rd_chk("wd rd a", A_WD, 4'h5);
    wd_q <= 1'b0;
    wd_h <= 1'b1;
    wd_o <= 1'b0;
    rd_chk("wd rd b", A_WD, 4'h2);
    stb_chk(A_TMR, 4'h0, 3'b000);
    `CHK("run off", 1'b0, sw_run);
  endtask

  task automatic t_serial;
    wr(A_SDL, 4'h3);
    wr(A_SDH, 4'hc);
    #1;
    `CHK("sdata", 8'hc3, sdata);
    pstrb <= 4'h0;
    wr(A_SDL, 4'hf);
    pstrb <= 4'hf;
    rd_chk("sd low", A_SDL, 4'h3);
    rd_chk("sd high", A_SDH, 4'hc);
    @(posedge clk);
    sload   <= 1'b1;
    sload_d <= 8'h5a;
    @(posedge clk);
    sload <= 1'b0;
    #1;
    `CHK("sdata load", 8'h5a, sdata);
    rd_chk("sd low ld", A_SDL, 4'ha);
  endtask

  task automatic t_mode;
    logic [1:0] mm;
    for (int m = 0; m < 4; m++) begin
      mm = 2'(m);
      wr(A_CFG, {mm, mm[0], ~mm[0]});
      #1;
      `CHK("mode", mm, smode);
      `CHK("halvings", (mm == 2'h3) ? 2'h0 : mm, shalv);
      `CHK("slave", mm == 2'h3, sslave);
      `CHK("edge en", {mm[0], ~mm[0]}, {sedge, sien});
      rd_chk("cfg rd", A_CFG, {mm, mm[0], ~mm[0]});
    end
  endtask

  task automatic t_flags;
    @(posedge clk);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("sio flag", 2'h1, {k2_fac, sifac});
    rd_chk("flags sio", A_FLG, 4'h1);
    #1;
    `CHK("sio clr", 1'b0, sifac);
    wr(A_K2E, 4'h1);
    #1;
    `CHK("k2 en", 4'h1, k2_en);
    rd_chk("k2 en rd", A_K2E, 4'h1);
    k2_pins <= 4'h2;
    repeat (6) @(posedge clk);
    #1;
    `CHK("k2 masked", 1'b0, k2_fac);
    k2_pins <= 4'h3;
    repeat (6) @(posedge clk);
    #1;
    `CHK("k2 flag", 1'b1, k2_fac);
    rd_chk("k2 lvl", A_K2L, 4'h3);
    rd_chk("flags k2", A_FLG, 4'h2);
    #1;
    `CHK("k2 clr", 1'b0, k2_fac);
  endtask

  task automatic t_bad;
    logic [3:0] r;
    logic       e;
    apb(1'b0, 12'hbd8, 4'h0, r, e);
    `CHK("bad rd err", 1'b1, e);
    `CHK("bad rd data", 4'h0, r);
    apb(1'b1, 12'h000, 4'h5, r, e);
    `CHK("bad wr err", 1'b1, e);
  endtask

  // ****************************************************
  // Run control
  // ****************************************************
  task automatic results;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Ceiling well above the roughly 150 cycles the scenarios need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end

  // Main sequence
  initial begin
    {reset_n, psel, penable, pwrite, sload, sdone, wd_q, wd_h, wd_o} = '0;
    {paddr, pwdata, sload_d, pin_in, k2_pins} = '0;
    pstrb = 4'hf;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    t_reset();
    t_port();
    t_timers();
    t_serial();
    t_mode();
    t_flags();
    t_bad();
    results();
  end
endmodule // nio_regs_tb_top
